// ---- hdl/bfs_pkg.sv ----
// Purpose: Shared constants for the buck sequencing supervisor
// Assumes: 200 MHz system clock
// Notes: Times kept in their own unit, cycle counts derived
package bfs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Soft-start length to the run state, microseconds; full current is set one step before
  localparam int unsigned SS_TOTAL_US = 1700;
  localparam int unsigned SS_STEPS = 5;
  localparam int unsigned SS_STEP_CYC = SS_TOTAL_US * CLK_MHZ / SS_STEPS;
  // Undervoltage check delay after leaving shutdown, microseconds
  localparam int unsigned UV_DELAY_US = 20000;
  localparam int unsigned UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;
  localparam logic [2:0] CURRENT_LIMIT_SET_RESET = 3'h0;
  localparam logic [2:0] CURRENT_LIMIT_SET_FULL = 3'h5;
  typedef enum logic [1:0] {
    BFS_OFF,
    BFS_SOFT,
    BFS_RUN
  } bfs_state_t;
endpackage

// ---- hdl/bfs_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to i_mclk
// Notes: First stage read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module bfs_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/bfs_top.sv ----
// Purpose: Power-on, lockout, soft-start, power-good and fault supervisor
// Assumes: All analog thresholds arrive as comparator levels
// Notes: Tracking or fixed thresholds chosen by i_fixed_thresh
`timescale 1ns/1ps
`default_nettype none
module bfs_top
  import bfs_pkg::*;
#(
  parameter int unsigned SS_STEP = SS_STEP_CYC,
  parameter int unsigned UV_DELAY = UV_DELAY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_supply_por,
  input wire logic i_supply_uvlo_ok,
  input wire logic i_power_off_request_n,
  input wire logic i_overvoltage_disable_in,
  input wire logic i_skip_below_gnd,
  input wire logic i_skip_high,
  input wire logic i_fixed_thresh,
  input wire logic i_fb_over_track,
  input wire logic i_fb_over_fixed,
  input wire logic i_fb_under_track,
  input wire logic i_fb_under_fixed,
  input wire logic i_fb_pg_low,
  input wire logic i_standby,
  input wire logic i_thermal_trip,
  input wire logic i_zero_cross,
  output logic o_low_side_gate,
  output logic o_switch_enable,
  output logic o_skip_enable,
  output logic [2:0] o_current_limit_set,
  output logic o_output_ok_flag,
  output logic o_fault
);
  localparam int W = 14;
  logic [W-1:0] raw;
  logic [W-1:0] s;
  logic por_ok;
  logic uvlo_ok;
  logic run_n;
  logic ovp_dis;
  logic test_mode;
  logic skip_hi;
  logic fixed;
  logic ov_tr;
  logic ov_fx;
  logic un_tr;
  logic un_fx;
  logic pg_low;
  logic stby;
  logic therm;
  logic run_d;
  logic uv_armed;
  logic [31:0] uv_cnt;
  logic [31:0] ss_cnt;
  logic fault;
  logic [2:0] current_limit_set;
  bfs_state_t state;
  logic ov_hit;
  logic uv_hit;
  logic off_low;

  // All checks share the one clock and rest during reset
  default clocking ast_cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  assign raw = {i_supply_por, i_supply_uvlo_ok, i_power_off_request_n,
    i_overvoltage_disable_in, i_skip_below_gnd, i_skip_high,
    i_fixed_thresh, i_fb_over_track, i_fb_over_fixed, i_fb_under_track,
    i_fb_under_fixed, i_fb_pg_low, i_standby, i_thermal_trip};

  bfs_sync #(
    .W(W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(raw),
    .o_sync(s)
  );

  assign {por_ok, uvlo_ok, run_n, ovp_dis, test_mode, skip_hi, fixed,
    ov_tr, ov_fx, un_tr, un_fx, pg_low, stby, therm} = s;

  // Disable input only masks overvoltage on the tracking variant; off_low uses it on both
  assign ov_hit = !test_mode &&
    (fixed ? ov_fx : (ov_tr && !ovp_dis));
  assign uv_hit = !test_mode && (fixed ? un_fx : un_tr);
  assign off_low = !run_n && ovp_dis;

  // Delayed run level for shutdown-toggle detection
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_d <= 1'b0;
    else
      run_d <= run_n;
  end

  // Shared fault latch
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fault <= 1'b0;
    else if (!por_ok || test_mode || !run_n)
      fault <= 1'b0;
    else if (ov_hit || (uv_armed && uv_hit && uv_cnt == 32'h0) ||
      (therm && !test_mode))
      fault <= 1'b1;
  end

  property p_test_clear;
    test_mode |=> !fault;
  endproperty
  AST_TEST_CLEAR: assert property (p_test_clear)
    else $error("fault held in test mode");

  // Only power loss, test mode or shutdown may drop it
  property p_fault_hold;
    (fault && por_ok && run_n && !test_mode) |=> fault;
  endproperty
  AST_FAULT_HOLD: assert property (p_fault_hold)
    else $error("fault latch dropped without a clear");

  // Trip lands one edge after the synced compare
  property p_ov_set;
    (ov_hit && por_ok && run_n) |=> fault;
  endproperty
  AST_OV_SET: assert property (p_ov_set)
    else $error("overvoltage did not set fault");

  // Undervoltage timer restarts on each shutdown exit made while power-on is good
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      uv_cnt <= 32'h0;
      uv_armed <= 1'b0;
    end
    else if (!por_ok || !run_n)
    begin
      uv_cnt <= 32'h0;
      uv_armed <= 1'b0;
    end
    else if (run_n && !run_d)
    begin
      uv_cnt <= 32'(UV_DELAY - 1);
      uv_armed <= 1'b1;
    end
    else if (uv_armed && uv_cnt != 32'h0)
      uv_cnt <= uv_cnt - 32'h1;
  end

  property p_uv_arm;
    (run_n && !run_d && por_ok) |=> uv_cnt == 32'(UV_DELAY - 1);
  endproperty
  AST_UV_ARM: assert property (p_uv_arm)
    else $error("undervoltage timer not restarted");

  // Checked continuously once the delay has run out
  property p_uv_trip;
    (uv_armed && uv_cnt == 32'h0 && uv_hit && por_ok && run_n) |=> fault;
  endproperty
  AST_UV_TRIP: assert property (p_uv_trip)
    else $error("undervoltage after delay did not latch");

  // Sequencer: lockout, soft-start, run
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= BFS_OFF;
      ss_cnt <= 32'h0;
      current_limit_set <= CURRENT_LIMIT_SET_RESET;
    end
    else if (!por_ok || !uvlo_ok || !run_n)
    begin
      state <= BFS_OFF;
      ss_cnt <= 32'h0;
      current_limit_set <= CURRENT_LIMIT_SET_RESET;
    end
    else
    begin
      case (state)
        BFS_OFF:
        begin
          state <= BFS_SOFT;
          current_limit_set <= 3'h1;
          ss_cnt <= 32'(SS_STEP - 1);
        end
        BFS_SOFT:
        begin
          if (ss_cnt != 32'h0)
            ss_cnt <= ss_cnt - 32'h1;
          else if (current_limit_set == CURRENT_LIMIT_SET_FULL)
            state <= BFS_RUN;
          else
          begin
            current_limit_set <= current_limit_set + 3'h1;
            ss_cnt <= 32'(SS_STEP - 1);
          end
        end
        BFS_RUN:
          state <= BFS_RUN;
        default:
          state <= BFS_OFF;
      endcase
    end
  end

  // Shutdown level, then release with supply good
  sequence s_shutdown_exit;
    !run_n ##1 (run_n && por_ok && uvlo_ok);
  endsequence

  property p_ss_restart;
    s_shutdown_exit |=> (state == BFS_SOFT && current_limit_set == 3'h1);
  endproperty
  AST_SS_RESTART: assert property (p_ss_restart)
    else $error("no new soft-start after shutdown exit");

  property p_current_limit_set_step;
    (state == BFS_SOFT && current_limit_set != $past(current_limit_set) && $past(state) == BFS_SOFT)
      |-> current_limit_set == $past(current_limit_set) + 3'h1;
  endproperty
  AST_CURRENT_LIMIT_SET_STEP: assert property (p_current_limit_set_step)
    else $error("current limit step wrong");

  // Run is only reached after the last step
  property p_current_limit_set_full;
    state == BFS_RUN |-> current_limit_set == CURRENT_LIMIT_SET_FULL;
  endproperty
  AST_CURRENT_LIMIT_SET_FULL: assert property (p_current_limit_set_full)
    else $error("run state below full current limit");

  property p_por_clr;
    !por_ok |=> (!fault && current_limit_set == CURRENT_LIMIT_SET_RESET);
  endproperty
  AST_POR_CLR: assert property (p_por_clr)
    else $error("power-on reset did not clear");

  // Gate and output registers
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_low_side_gate <= 1'b1;
      o_switch_enable <= 1'b0;
      o_skip_enable <= 1'b0;
      o_current_limit_set <= CURRENT_LIMIT_SET_RESET;
      o_output_ok_flag <= 1'b0;
      o_fault <= 1'b0;
    end
    else
    begin
      // Gate high pulls the output to ground, so it is the safe state
      o_low_side_gate <= !off_low && (!uvlo_ok || !run_n || fault ||
        !por_ok);
      o_switch_enable <= por_ok && uvlo_ok && run_n && !fault &&
        state != BFS_OFF;
      o_skip_enable <= (test_mode || !skip_hi) && i_zero_cross;
      o_current_limit_set <= current_limit_set;
      o_output_ok_flag <= run_n && !stby && !pg_low && por_ok &&
        uvlo_ok;
      o_fault <= fault;
    end
  end

  property p_gate_lockout;
    (!uvlo_ok && por_ok && !off_low) |=> o_low_side_gate;
  endproperty
  AST_GATE_LOCKOUT: assert property (p_gate_lockout)
    else $error("low gate not high in lockout");

  property p_pg_off;
    (!run_n || stby) |=> !o_output_ok_flag;
  endproperty
  AST_PG_OFF: assert property (p_pg_off)
    else $error("power-good high while off");

  property p_pg_drop;
    pg_low |=> !o_output_ok_flag;
  endproperty
  AST_PG_DROP: assert property (p_pg_drop)
    else $error("power-good high with feedback low");

  // Fault latch must not pull power-good down
  property p_pg_indep;
    (fault && run_n && !stby && !pg_low && por_ok && uvlo_ok)
      |=> o_output_ok_flag;
  endproperty
  AST_PG_INDEP: assert property (p_pg_indep)
    else $error("power-good tied to fault latch");

  property p_no_sw_lock;
    !uvlo_ok |=> !o_switch_enable;
  endproperty
  AST_NO_SW_LOCK: assert property (p_no_sw_lock)
    else $error("switching in lockout");

  // A shutdown with the disable input high right after the trip may legally drop the gate
  sequence s_ov_trip;
    (ov_hit && run_n && por_ok) ##1 !off_low;
  endsequence

  property p_ov_latch;
    s_ov_trip |=> o_low_side_gate;
  endproperty
  AST_OV_LATCH: assert property (p_ov_latch)
    else $error("overvoltage did not force gate");

  property p_off2_low;
    off_low |=> !o_low_side_gate;
  endproperty
  AST_OFF2_LOW: assert property (p_off2_low)
    else $error("second shutdown gate not low");

  property p_skip_forced;
    (test_mode && i_zero_cross) |=> o_skip_enable;
  endproperty
  AST_SKIP_FORCED: assert property (p_skip_forced)
    else $error("test mode did not allow pulse skipping");
endmodule
`default_nettype wire

// ---- sim/bfs_stage_model.sv ----
// Purpose: Power stage stand-in that reports inductor zero crossings
// Assumes: Crossings only occur while switching is enabled
// Notes: Line toggles every cycle while switching is enabled, so no stale level is seen
`timescale 1ns/1ps
`default_nettype none
module bfs_stage_model (
  input wire logic i_mclk,
  input wire logic i_switch_enable,
  output logic o_zero_cross
);
  logic phase = 1'b0;
  // Feedback levels come from the bench in 1 LSB moves only
  // Test mode entry is a level the bench holds, like a sunk pin
  always @(posedge i_mclk)
  begin
    phase <= ~phase;
  end
  assign o_zero_cross = i_switch_enable & phase;
endmodule
`default_nettype wire

// ---- sim/bfs_top_tb.sv ----
// Purpose: Self-checking bench for the buck sequencing supervisor
// Assumes: Short soft-start and undervoltage counts via parameters
// Notes: Waits of 6 cycles cover the 3 to 4 cycle answer latency
`timescale 1ns/1ps
`default_nettype none
module bfs_top_tb;
  import bfs_pkg::*;
  localparam int unsigned SSN = 10;
  localparam int unsigned UVN = 50;
  logic i_mclk = 0;
  logic i_rst_n = 0;
  logic por = 0, uvlo = 0, run_n = 0, ovd = 0, tst = 0, fix = 0;
  logic ovt = 0, ovf = 0, uvt = 0, uvf = 0, pgl = 0, stb = 0, thr = 0;
  logic skh = 0;
  logic zc, gate, sw, skp, ok, flt;
  logic [2:0] current_limit_set;
  int bad_count = 0;
  int compares = 0;
  always #2.5 i_mclk = ~i_mclk;
  bfs_stage_model stage_u (.i_mclk(i_mclk), .i_switch_enable(sw),
    .o_zero_cross(zc));
  bfs_top #(.SS_STEP(SSN), .UV_DELAY(UVN)) dut_u (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_supply_por(por), .i_supply_uvlo_ok(uvlo),
    .i_power_off_request_n(run_n), .i_overvoltage_disable_in(ovd),
    .i_skip_below_gnd(tst), .i_skip_high(skh), .i_fixed_thresh(fix),
    .i_fb_over_track(ovt), .i_fb_over_fixed(ovf), .i_fb_under_track(uvt),
    .i_fb_under_fixed(uvf), .i_fb_pg_low(pgl), .i_standby(stb),
    .i_thermal_trip(thr), .i_zero_cross(zc), .o_low_side_gate(gate),
    .o_switch_enable(sw), .o_skip_enable(skp),
    .o_current_limit_set(current_limit_set), .o_output_ok_flag(ok), .o_fault(flt));
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [2:0] e,
    input logic [2:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_n(input string n, input int e, input int g);
    compares++;
    if (g != e)
    begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // Skip output must follow the crossing seen one edge before
  task automatic chk_skip();
    logic z;
    repeat (2)
    begin
      z = zc;
      cyc(1);
      chk("skp", {2'h0, z}, {2'h0, skp});
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic s_lockout();
    por = 1;
    run_n = 1;
    cyc(6);
    chk("gate", 3'h1, {2'h0, gate});
    chk("sw", 3'h0, {2'h0, sw});
    chk("current_limit_set", CURRENT_LIMIT_SET_RESET, current_limit_set);
  endtask
  task automatic s_soft();
    int gap;
    logic [2:0] last;
    uvlo = 1;
    last = CURRENT_LIMIT_SET_RESET;
    gap = 0;
    // Each step must come exactly one step period after the last
    for (int t = 0; t < 12 * SSN && last !== CURRENT_LIMIT_SET_FULL; t++)
    begin
      cyc(1);
      gap++;
      if (current_limit_set !== last)
      begin
        chk("current_limit_set", last + 3'h1, current_limit_set);
        if (last != CURRENT_LIMIT_SET_RESET)
          chk_n("gap", SSN, gap);
        last = current_limit_set;
        gap = 0;
      end
    end
    chk("current_limit_set", CURRENT_LIMIT_SET_FULL, current_limit_set);
    if (current_limit_set !== CURRENT_LIMIT_SET_FULL)
      conclude();
  endtask
  task automatic s_output_ok_flag();
    cyc(6);
    chk("ok", 3'h1, {2'h0, ok});
    pgl = 1;
    cyc(6);
    chk("ok", 3'h0, {2'h0, ok});
    chk("flt", 3'h0, {2'h0, flt});
    pgl = 0;
    stb = 1;
    cyc(6);
    chk("ok", 3'h0, {2'h0, ok});
    stb = 0;
    skh = 1;
    cyc(3);
    chk("skp", 3'h0, {2'h0, skp});
    cyc(1);
    chk("skp", 3'h0, {2'h0, skp});
    skh = 0;
    cyc(3);
    chk_skip();
  endtask
  task automatic s_ov(input logic f, input logic d);
    logic trip;
    trip = f | ~d;
    fix = f;
    ovd = d;
    ovt = ~f;
    ovf = f;
    cyc(7);
    chk("flt", {2'h0, trip}, {2'h0, flt});
    chk("gate", {2'h0, trip}, {2'h0, gate});
    ovt = 0;
    ovf = 0;
    cyc(6);
    chk("gate", {2'h0, trip}, {2'h0, gate});
    run_n = 0;
    cyc(6);
    chk("gate", {2'h0, ~d}, {2'h0, gate});
    chk("ok", 3'h0, {2'h0, ok});
    run_n = 1;
    cyc(6);
    chk("flt", 3'h0, {2'h0, flt});
    chk("current_limit_set", 3'h1, current_limit_set);
    ovd = 0;
  endtask
  task automatic s_uv();
    fix = 1;
    uvf = 1;
    cyc(6);
    chk("flt", 3'h0, {2'h0, flt});
    cyc(UVN + 10);
    chk("flt", 3'h1, {2'h0, flt});
    chk("sw", 3'h0, {2'h0, sw});
    tst = 1;
    skh = 1;
    ovf = 1;
    thr = 1;
    cyc(7);
    chk("flt", 3'h0, {2'h0, flt});
    chk_skip();
    tst = 0;
    skh = 0;
    cyc(7);
    chk("flt", 3'h1, {2'h0, flt});
  endtask
  initial
  begin
    repeat (16) @(posedge i_mclk);
    #1;
    i_rst_n = 1;
    s_lockout();
    s_soft();
    s_output_ok_flag();
    s_ov(1'b0, 1'b0);
    s_ov(1'b1, 1'b0);
    s_ov(1'b0, 1'b1);
    s_uv();
    conclude();
  end
endmodule
`default_nettype wire
